// >>> hw/sacd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SACD_MAP_SVH
`define SACD_MAP_SVH
`define SACD_OFS_CTRL 3'h0
`define SACD_OFS_RESULT 3'h1
`define SACD_OFS_CLKDIV 3'h2
`define SACD_OFS_PINCTRL 3'h3
`define SACD_OFS_IRQ_ST 3'h4
`define SACD_OFS_IRQ_MSK 3'h5
`define SACD_BIT_TRIG 15
`define SACD_BIT_ONE_SHOT 10
`define SACD_BIT_BUSY 15
`define SACD_BIT_HIDE 14
`define SACD_CHANNEL_TAG_HI 14
`define SACD_CHANNEL_TAG_LO 12
`define SACD_DIV_HI 14
`define SACD_PIN_WR_MASK 16'h773f
`define SACD_RST_16 16'h0000
`define SACD_START_TICKS 5'h03
`define SACD_CONV_TICKS 5'h20
`define SACD_SYS_CLK_KHZ 40000
`define SACD_SAR_MAX_KHZ 2000
`define SACD_DIV_MIN ((`SACD_SYS_CLK_KHZ + `SACD_SAR_MAX_KHZ - 1) / `SACD_SAR_MAX_KHZ - 1)
`define SACD_EVT_DONE 0
`define SACD_EVT_START 1
`endif

// >>> hw/sacd_pkg.sv
// Types shared by the converter control block
`default_nettype none
package sacd_pkg;
  typedef enum logic [3:0] {
    SACD_IDLE = 4'h1,
    SACD_START = 4'h2,
    SACD_CONV = 4'h4,
    SACD_HOLD = 4'h8
  } sacd_state_t;
endpackage
`default_nettype wire

// >>> hw/sacd_clk_if.sv
// Divisor and divided tick between the control block and its divider
`timescale 1ns/10ps
`default_nettype none
interface sacd_clk_if;
  logic [14:0] divisor;
  logic tick;
  modport ctl_side (output divisor, input tick);
  modport div_side (input divisor, output tick);
endinterface
`default_nettype wire

// >>> hw/sacd_clk_div.sv
// Converter clock divider, one enable pulse every divisor+1 cycles
`timescale 1ns/10ps
`default_nettype none
module sacd_clk_div import sacd_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Divisor in, tick out
  sacd_clk_if.div_side clk
);
  // Divider state
  typedef struct packed {
    logic [14:0] cnt;
  } sacd_div_st_t;
  sacd_div_st_t st_ff;
  sacd_div_st_t nxt_st;

  // A lowered divisor can leave the count above it, so compare with >=
  assign clk.tick = (st_ff.cnt >= clk.divisor);

  // Count up, restart on each tick
  always_comb begin
    nxt_st = st_ff;
    if (clk.tick) begin
      nxt_st.cnt = 15'h0000;
    end else begin
      nxt_st.cnt = st_ff.cnt + 15'h0001;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A divisor rewritten to zero right after a tick legally ticks again at once
  chk_div_gap: assert property (@(posedge ref_clk) disable iff (reset)
    clk.tick && clk.divisor != 15'h0000 |=> !clk.tick || clk.divisor == 15'h0000)
    else $error("divided tick came twice in a row");
endmodule
`default_nettype wire

// >>> hw/sacd_top.sv
// Converter result register, sequencer and clock control
// How it works
// - Busy rises three converter ticks after trigger
// - Bit 15 busy, bits 9-0 the sample
// - Hide-status set forces busy read to zero
// - Bits 14-12 carry the sample's channel
// - Hide-status set forces channel read to zero
// - Converter tick every divisor plus one cycles
// - Pin control bit 14 zeroes result bits 15-12
// - Hide-status clear shows busy and channel
// - Continuous mode repeats while trigger stays set
// - One-shot converts once, needs trigger re-arm
// - Each conversion lasts 32 converter ticks
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sacd_map.svh"
module sacd_top import sacd_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Analog core side
  output logic core_tick,
  output logic core_convert,
  output logic [2:0] core_channel,
  output logic [15:0] core_pin_ctrl,
  input wire logic [9:0] core_sample
);

  ////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////

  // All state of the block in one record
  typedef struct packed {
    sacd_state_t state; // Sequencer state
    logic [4:0] cnt; // Converter tick count
    logic trig; // Conversion trigger
    logic one_shot; // One-shot select
    logic [2:0] channel_tag_sel; // Channel to convert next
    logic [2:0] conv_channel_tag; // Channel being converted
    logic busy; // Conversion in progress
    logic [9:0] sample; // Last sample value
    logic [2:0] channel_tag_tag; // Channel of last sample
    logic [14:0] div; // Converter clock divisor
    logic [15:0] pin; // Reference and pin control
    logic [1:0] irq_st; // Sticky events
    logic [1:0] irq_msk; // Event mask
    logic [15:0] rdata; // Read data
  } sacd_st_t;

  sacd_st_t st_ff; // Registered state
  sacd_st_t nxt_st; // Next state
  logic tick; // Converter clock enable
  logic hide; // Hide-status-bits control
  logic too_fast; // Divisor breaks the 2MHz limit
  logic [1:0] evt; // Events raised this cycle
  logic [1:0] clr; // Events cleared this cycle

  sacd_clk_if clk_if ();

  ////////////////////////////////////////////////////////////////
  // Divider
  ////////////////////////////////////////////////////////////////

  // Divider sits apart so its count never mixes with the sequencer
  sacd_clk_div u_div (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk(clk_if.div_side)
  );

  assign clk_if.divisor = st_ff.div;
  assign tick = clk_if.tick;

  ////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////

  // Result word as software sees it
  function automatic logic [15:0] result_word(input sacd_st_t s, input logic h);
    logic [15:0] w;
    w = '0; // Reserved 11-10 stay zero
    w[9:0] = s.sample;
    if (!h) begin
      w[`SACD_BIT_BUSY] = s.busy;
      w[`SACD_CHANNEL_TAG_HI:`SACD_CHANNEL_TAG_LO] = s.channel_tag_tag;
    end
    // Hidden: upper four bits stay 0000 for DMA copies
    return w;
  endfunction

  // Read multiplexer, unmapped offsets read zero
  function automatic logic [15:0] read_mux(input sacd_st_t s, input logic [2:0] a,
                                           input logic h, input logic f);
    logic [15:0] w;
    w = '0;
    unique case (a)
      `SACD_OFS_CTRL: begin
        w[`SACD_BIT_TRIG] = s.trig;
        w[`SACD_CHANNEL_TAG_HI:`SACD_CHANNEL_TAG_LO] = s.channel_tag_sel;
        w[`SACD_BIT_ONE_SHOT] = s.one_shot;
        w[0] = f;
      end
      `SACD_OFS_RESULT: w = result_word(s, h);
      `SACD_OFS_CLKDIV: w[`SACD_DIV_HI:0] = s.div; // Bit 15 zero
      `SACD_OFS_PINCTRL: w = s.pin;
      `SACD_OFS_IRQ_ST: w[1:0] = s.irq_st;
      `SACD_OFS_IRQ_MSK: w[1:0] = s.irq_msk;
      default: w = '0;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////

  assign hide = st_ff.pin[`SACD_BIT_HIDE];
  // Only flagged; the divisor is software's to keep legal
  assign too_fast = (st_ff.div < 15'(`SACD_DIV_MIN));

  // Sequencer, register writes and events
  always_comb begin
    nxt_st = st_ff;
    evt = 2'h0;
    clr = 2'h0;
    // Read data lives one cycle only
    nxt_st.rdata = reg_rd ? read_mux(st_ff, reg_addr, hide, too_fast) : `SACD_RST_16;
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `SACD_OFS_CTRL: begin
          nxt_st.trig = reg_wdata[`SACD_BIT_TRIG];
          nxt_st.channel_tag_sel = reg_wdata[`SACD_CHANNEL_TAG_HI:`SACD_CHANNEL_TAG_LO];
          nxt_st.one_shot = reg_wdata[`SACD_BIT_ONE_SHOT];
        end
        `SACD_OFS_CLKDIV: begin
          nxt_st.div = reg_wdata[`SACD_DIV_HI:0]; // Bit 15 dropped
        end
        `SACD_OFS_PINCTRL: begin
          nxt_st.pin = reg_wdata & `SACD_PIN_WR_MASK;
        end
        `SACD_OFS_IRQ_ST: begin
          clr = reg_wdata[1:0];
        end
        `SACD_OFS_IRQ_MSK: begin
          nxt_st.irq_msk = reg_wdata[1:0];
        end
        default: begin
          // Result is read only, others unmapped
        end
      endcase
    end
    // Sequencer
    unique case (st_ff.state)
      SACD_IDLE: begin
        // Wait for the trigger
        if (st_ff.trig) begin
          nxt_st.state = SACD_START;
          // A tick here already follows the trigger, so it is the first of three
          if (tick) begin
            nxt_st.cnt = 5'h01;
          end else begin
            nxt_st.cnt = 5'h00;
          end
        end
      end
      SACD_START: begin
        // Count start-up ticks before raising busy
        if (tick) begin
          if (st_ff.cnt == `SACD_START_TICKS - 5'h01) begin
            nxt_st.state = SACD_CONV;
            nxt_st.cnt = 5'h00;
            nxt_st.busy = 1'b1;
            nxt_st.conv_channel_tag = st_ff.channel_tag_sel;
            evt[`SACD_EVT_START] = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 5'h01;
          end
        end
      end
      SACD_CONV: begin
        // Trigger cleared mid-way still finishes the sample
        if (tick) begin
          if (st_ff.cnt == `SACD_CONV_TICKS - 5'h01) begin
            nxt_st.sample = core_sample;
            nxt_st.channel_tag_tag = st_ff.conv_channel_tag;
            nxt_st.busy = 1'b0;
            nxt_st.cnt = 5'h00;
            evt[`SACD_EVT_DONE] = 1'b1;
            if (st_ff.one_shot) begin
              nxt_st.state = SACD_HOLD;
            end else if (st_ff.trig) begin
              nxt_st.state = SACD_START;
            end else begin
              nxt_st.state = SACD_IDLE;
            end
          end else begin
            nxt_st.cnt = st_ff.cnt + 5'h01;
          end
        end
      end
      SACD_HOLD: begin
        // One-shot: trigger must drop before another sample
        if (!st_ff.trig) begin
          nxt_st.state = SACD_IDLE;
        end
      end
      default: begin
        nxt_st.state = SACD_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle
    nxt_st.irq_st = (st_ff.irq_st & ~clr) | evt;
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////

  // Single state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.state <= SACD_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////

  assign reg_rdata = st_ff.rdata;
  assign irq = |(st_ff.irq_st & st_ff.irq_msk);
  assign core_tick = tick;
  assign core_convert = st_ff.busy;
  assign core_channel = st_ff.conv_channel_tag;
  assign core_pin_ctrl = st_ff.pin;

  ////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////

  logic rd_res_q; // Result read last cycle
  logic hide_q; // Hide control at that read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_res_q <= 1'b0;
      hide_q <= 1'b0;
    end else begin
      rd_res_q <= reg_rd && reg_addr == `SACD_OFS_RESULT;
      hide_q <= hide;
    end
  end

  chk_busy_three_ticks: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(st_ff.busy) |-> $past(tick) && $past(st_ff.cnt) == `SACD_START_TICKS - 5'h01
      && $past(st_ff.state) == SACD_START)
    else $error("busy rose without three start ticks");

  chk_hidden_busy: assert property (@(posedge ref_clk) disable iff (reset)
    rd_res_q && hide_q |-> reg_rdata[15] == 1'b0)
    else $error("busy visible while hidden");

  chk_hidden_channel_tag: assert property (@(posedge ref_clk) disable iff (reset)
    rd_res_q && hide_q |-> reg_rdata[14:12] == 3'h0)
    else $error("channel visible while hidden");

  chk_shown_status: assert property (@(posedge ref_clk) disable iff (reset)
    rd_res_q && !hide_q |-> reg_rdata[15:12] == {$past(st_ff.busy), $past(st_ff.channel_tag_tag)})
    else $error("status bits wrong while shown");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
    rd_res_q |-> reg_rdata[11:10] == 2'h0 && reg_rdata[9:0] == $past(st_ff.sample))
    else $error("result reserved bits or sample wrong");

  chk_conv_length: assert property (@(posedge ref_clk) disable iff (reset)
    st_ff.state == SACD_CONV && tick && st_ff.cnt == `SACD_CONV_TICKS - 5'h01
      |=> !st_ff.busy && st_ff.irq_st[0])
    else $error("conversion did not end on tick 32");

  chk_oneshot_holds: assert property (@(posedge ref_clk) disable iff (reset)
    st_ff.state == SACD_HOLD && st_ff.trig && !(reg_wr && reg_addr == `SACD_OFS_CTRL)
      |=> st_ff.state == SACD_HOLD && !st_ff.busy)
    else $error("one-shot restarted without re-arm");

  chk_continuous: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(st_ff.busy) && $past(st_ff.trig) && !$past(st_ff.one_shot)
      |-> st_ff.state == SACD_START)
    else $error("continuous mode stopped");

  chk_sample_tag: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(st_ff.busy) |-> st_ff.channel_tag_tag == $past(st_ff.conv_channel_tag)
      && st_ff.sample == $past(core_sample))
    else $error("sample and tag not updated with busy");

  // Sequencer and register checks; these watch state that the
  // result-word checks above never reach

  // A tick beside the registered trigger must count toward the three
  chk_first_tick: assert property (@(posedge ref_clk) disable iff (reset)
    st_ff.state == SACD_IDLE && st_ff.trig && tick
      |=> st_ff.state == SACD_START && st_ff.cnt == 5'h01)
    else $error("tick beside the trigger not counted");

  // Busy is high exactly while the sequencer converts
  chk_busy_in_conv: assert property (@(posedge ref_clk) disable iff (reset)
    st_ff.busy == (st_ff.state == SACD_CONV))
    else $error("busy flag out of step with the sequencer");

  // The core must see the channel picked when busy rose
  chk_channel_tag_latch: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(st_ff.busy) |-> core_channel == $past(st_ff.channel_tag_sel))
    else $error("converted channel not taken at start");

  // Clearing the trigger re-arms a finished one-shot
  chk_hold_release: assert property (@(posedge ref_clk) disable iff (reset)
    st_ff.state == SACD_HOLD && !st_ff.trig
      |=> st_ff.state == SACD_IDLE && !st_ff.busy)
    else $error("one-shot did not release after trigger cleared");

  // Divider word: reserved top bit reads zero beside the stored divisor
  chk_div_reserved: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == `SACD_OFS_CLKDIV
      |=> reg_rdata[15] == 1'b0 && reg_rdata[`SACD_DIV_HI:0] == $past(st_ff.div))
    else $error("divider read shows reserved bit or wrong divisor");

  cov_done: cover property (@(posedge ref_clk) $fell(st_ff.busy));
  cov_hidden_read: cover property (@(posedge ref_clk) rd_res_q && hide_q);
  cov_hold: cover property (@(posedge ref_clk) st_ff.state == SACD_HOLD);
  cov_irq: cover property (@(posedge ref_clk) $rose(irq));
  cov_restart: cover property (@(posedge ref_clk) st_ff.state == SACD_CONV ##1 st_ff.state == SACD_START);
endmodule
`default_nettype wire

// >>> verif/sacd_core_model.sv
// Behavioural analog core that answers the block's conversion requests
`timescale 1ns/10ps
`default_nettype none
module sacd_core_model (
  // Clock
  input wire logic ref_clk,
  // Request from the block
  input wire logic core_convert,
  // Value the bench wants converted
  input wire logic [9:0] value,
  // Answer to the block
  output logic [9:0] core_sample
);
  ////////////////////////////////////////////////////////////////////////////////
  // The answer is steady only while a conversion runs; outside it the lines
  // wander every cycle, so sampling at the wrong moment shows up as garbage
  initial core_sample = 10'h000;
  always @(posedge ref_clk) begin
    if (core_convert) begin
      core_sample <= value;
    end else begin
      core_sample <= ~core_sample;
    end
  end
endmodule
`default_nettype wire

// >>> verif/sar_adc_result_and_clock_bench.sv
// Self-checking bench for the converter result register and clock divider
`timescale 1ns/10ps
`default_nettype none
`include "sacd_map.svh"
module sar_adc_result_and_clock_bench;
  // Design stimulus and responses
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq;
  logic core_tick;
  logic core_convert;
  logic [2:0] core_channel;
  logic [15:0] core_pin_ctrl;
  logic [9:0] core_sample;
  // Reference model state
  logic [9:0] value = 10'h000;
  int divs[4] = '{0, 1, 19, 5};
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int bt = 0;
  int n;
  int m;
  logic [15:0] r;

  ////////////////////////////////////////////////////////////////////////////////
  sacd_top i_sacd_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .core_tick(core_tick),
    .core_convert(core_convert), .core_channel(core_channel), .core_pin_ctrl(core_pin_ctrl),
    .core_sample(core_sample));
  sacd_core_model i_sacd_core_model (.ref_clk(ref_clk), .core_convert(core_convert), .value(value),
    .core_sample(core_sample));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  // Converter ticks seen while busy; bench clears it once, when the one-shot busy rises
  always @(posedge ref_clk) begin
    if (core_convert === 1'b1 && core_tick === 1'b1) bt++;
  end
  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Counts converter ticks until busy reaches a level, bounded
  task automatic ticks_to(input logic lvl, output int t);
    t = 0;
    for (int i = 0; i < 3000 && core_convert !== lvl; i++) begin
      @(posedge ref_clk);
      if (core_tick === 1'b1) t++;
      #1;
    end
  endtask
  // Cycles from one tick to the next
  task automatic period(output int p);
    p = 0;
    do @(posedge ref_clk); while (core_tick !== 1'b1);
    do begin
      @(posedge ref_clk);
      p++;
    end while (core_tick !== 1'b1 && p < 40000);
  endtask
  // Irq may be registered, so look one edge later
  task automatic irq_is(input logic b);
    @(posedge ref_clk);
    #1 check({15'h0000, irq}, {15'h0000, b});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(56);
    divs[3] = $urandom_range(9, 2);
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values, unmapped words included; divisor zero trips the too-fast flag
    rd(`SACD_OFS_CTRL, r);
    check(r, 16'h0001);
    for (int a = 1; a < 8; a++) begin
      rd(3'(a), r);
      check(r, 16'h0000);
    end
    wr(`SACD_OFS_CLKDIV, 16'hffff);
    rd(`SACD_OFS_CLKDIV, r);
    check(r, 16'h7fff);
    wr(`SACD_OFS_PINCTRL, 16'hffff);
    rd(`SACD_OFS_PINCTRL, r);
    check(r, 16'h773f);
    check(core_pin_ctrl, 16'h773f);
    // Tick spacing for several divisors; the first period after a write is skipped
    foreach (divs[k]) begin
      wr(`SACD_OFS_CLKDIV, 16'(divs[k]));
      period(m);
      period(m);
      check(16'(m), 16'(divs[k] + 1));
    end
    // One-shot on channel 5 at the fastest legal converter clock
    wr(`SACD_OFS_CLKDIV, 16'(`SACD_DIV_MIN));
    rd(`SACD_OFS_CTRL, r);
    check(r, 16'h0000);
    wr(`SACD_OFS_PINCTRL, 16'h0000);
    wr(`SACD_OFS_IRQ_MSK, 16'h0001);
    value <= 10'($urandom);
    wr(`SACD_OFS_CTRL, 16'hd400);
    ticks_to(1'b1, n);
    bt = 0;
    check(16'(n), 16'h0003);
    check({13'h0000, core_channel}, 16'h0005);
    rd(`SACD_OFS_RESULT, r);
    check(r & 16'h8000, 16'h8000);
    wr(`SACD_OFS_PINCTRL, 16'h4000);
    rd(`SACD_OFS_RESULT, r);
    check(r & 16'h8000, 16'h0000);
    ticks_to(1'b0, n);
    check(16'(bt), 16'h0020);
    rd(`SACD_OFS_RESULT, r);
    check(r, {6'h00, value});
    wr(`SACD_OFS_PINCTRL, 16'h0000);
    rd(`SACD_OFS_RESULT, r);
    check(r, {4'h5, 2'b00, value});
    repeat (100) @(posedge ref_clk);
    check({15'h0000, core_convert}, 16'h0000);
    // Interrupt raised, masked and cleared
    irq_is(1'b1);
    wr(`SACD_OFS_IRQ_MSK, 16'h0000);
    irq_is(1'b0);
    wr(`SACD_OFS_IRQ_MSK, 16'h0001);
    irq_is(1'b1);
    wr(`SACD_OFS_IRQ_ST, 16'h0001);
    irq_is(1'b0);
    rd(`SACD_OFS_IRQ_ST, r);
    check(r, 16'h0002);
    wr(`SACD_OFS_IRQ_ST, 16'h0002);
    rd(`SACD_OFS_IRQ_ST, r);
    check(r, 16'h0000);
    // Re-arm, then continuous mode on every channel code
    wr(`SACD_OFS_CTRL, 16'h0000);
    wr(`SACD_OFS_CLKDIV, 16'(`SACD_DIV_MIN));
    for (int c = 0; c < 8; c++) begin
      value <= 10'($urandom);
      wr(`SACD_OFS_CTRL, {1'b1, 3'(c), 12'h000});
      ticks_to(1'b1, n);
      check(16'(n), 16'h0003);
      check({13'h0000, core_channel}, 16'(c));
      ticks_to(1'b0, n);
      ticks_to(1'b1, n);
      check(16'(n), 16'h0003);
      wr(`SACD_OFS_CTRL, 16'h0000);
      ticks_to(1'b0, n);
      rd(`SACD_OFS_RESULT, r);
      check(r, {1'b0, 3'(c), 2'b00, value});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
